// ===== erc_encoder_referencing_control.v
// encoder control/status word engine for one encoder channel
// Behaviour
// (R1) control bit 7 chooses flying referencing (1) or cam search (0) for bits 0-3
// (R2) search: bits 0,1 cam 1, bits 2,3 cam 2; even positive, odd negative
// (R3) flying: bits 0-3 are rising/falling edges of cam 1 then cam 2
// (R4) control bit 4 activates the function requested by bits 0-3
// (R5) control bit 5 reads out the value selected by bits 0-3
// (R6) control bit 13 requests cyclic position value in the secondary word
// (R7) control bit 14 requests the encoder to be parked
// (R8) fault acknowledged on the rising edge of control bit 15, not level
// (R9) search mode: status bits 0,1 cam 1 search active, 2,3 cam 2
// (R10) flying mode: status bits 0-3 show flying referencing active per edge
// (R11) status bits 4-7: at cam in search, edge referencing done in flying
// (R12) status bits 8 and 9 mirror reference cam 1 and cam 2 levels
// (R13) status bit 11 set while a fault acknowledgement is processed
// (R14) status bit 13 set when secondary word holds cyclic position value; code keeps it set in cyclic mode while a read with bits 0-3 zero puts code 5 there
// (R15) status bit 14 set while the encoder is parked
// (R16) status bit 15 set on encoder fault, code held in fault code output
// (R17) transferred position value starts at zero after power-up
// (R18) unsupported function reports code 3841 in the secondary word
// (R19) reserved control bits ignored; status bits 10 and 12 return zero
`include "erc_defines.vh"
module erc_encoder_referencing_control (
  input  wire        clk_sys,              // 20 MHz system clock
  input  wire        rst,                  // async reset, active high
  input  wire [15:0] encoderControlWord,   // control word from controller, telegram clock
  input  wire        camLevel1,            // reference cam 1 pin
  input  wire        camLevel2,            // reference cam 2 pin
  input  wire        encoderFaultIn,       // encoder fault level from encoder logic
  input  wire [31:0] encoderFaultCode,     // code of present encoder fault
  input  wire [31:0] encoderPosition,      // live encoder position (same clock)
  input  wire [3:0]  funcSupported,        // which of functions 1-4 exist
  output reg  [15:0] encoderStatusWord,    // status word to controller
  output reg  [31:0] secondaryPosition,    // secondary position word
  output reg  [31:0] faultCodeParameter    // fault code of present fault
);

  localparam ST_IDLE   = 3'b001;
  localparam ST_SEARCH = 3'b010;
  localparam ST_FLYING = 3'b100;

  reg [2:0]  state_r;
  reg [3:0]  activeFunc_r;
  reg [3:0]  doneFunc_r;
  reg        camSync1a_r;
  reg        camSync1b_r;
  reg        camSync2a_r;
  reg        camSync2b_r;
  reg        camPrev1_r;
  reg        camPrev2_r;
  reg        ackPrev_r;
  reg [3:0]  ackCount_r;
  reg        fault_r;
  reg        parked_r;
  reg        cyclicOn_r;
  reg [31:0] position_r;
  reg        actPrev_r;
  reg [3:0]  ackCount_nxt;
  reg        fault_nxt;

  wire [3:0] funcReq  = encoderControlWord[`ERC_CW_FUNC_HI:`ERC_CW_FUNC_LO];
  wire       flyMode  = encoderControlWord[`ERC_CW_MODE];
  wire       activate = encoderControlWord[`ERC_CW_ACTIVATE];
  wire       readReq  = encoderControlWord[`ERC_CW_READ];
  wire       ackBit   = encoderControlWord[`ERC_CW_ACK];

  // per-function cam level: bits 0,1 belong to cam 1, bits 2,3 to cam 2
  function camOf;
    input [1:0] idx;
    input       c1;
    input       c2;
    begin
      camOf = idx[1] ? c2 : c1;
    end
  endfunction

  // per-function edge hit: even bit rising edge, odd bit falling edge
  function edgeHit;
    input [1:0] idx;
    input       c1;
    input       p1;
    input       c2;
    input       p2;
    reg         cur;
    reg         prv;
    begin
      cur = idx[1] ? c2 : c1;
      prv = idx[1] ? p2 : p1;
      edgeHit = idx[0] ? (prv & ~cur) : (~prv & cur);
    end
  endfunction

  wire       ackRise = ackBit & ~ackPrev_r; // level ignored, only the step [R8]
  wire       actRise = activate & ~actPrev_r; // a held bit must not restart a done function [R4]
  wire       unsupported = activate & (|(funcReq & ~funcSupported)); // [R18]
  wire [3:0] camHere;
  wire [3:0] edgeNow;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gFunc
      localparam [31:0] FUNC_IDX = g;
      assign camHere[g] = camOf(FUNC_IDX[1:0], camSync1b_r, camSync2b_r); // [R2]
      assign edgeNow[g] = edgeHit(FUNC_IDX[1:0], camSync1b_r, camPrev1_r,
                                  camSync2b_r, camPrev2_r); // [R3]
    end
  endgenerate

  // cam pins come from outside: two stages before use
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      camSync1a_r <= 1'b0;
      camSync1b_r <= 1'b0;
      camSync2a_r <= 1'b0;
      camSync2b_r <= 1'b0;
      camPrev1_r  <= 1'b0;
      camPrev2_r  <= 1'b0;
    end
    else
    begin
      camSync1a_r <= camLevel1;
      camSync1b_r <= camSync1a_r;
      camSync2a_r <= camLevel2;
      camSync2b_r <= camSync2a_r;
      camPrev1_r  <= camSync1b_r;
      camPrev2_r  <= camSync2b_r;
    end
  end

  // referencing function state machine
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r      <= ST_IDLE;
      activeFunc_r <= 4'h0;
      doneFunc_r   <= 4'h0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (actRise && !unsupported && !parked_r && funcReq != 4'h0) // [R4]
          begin
            activeFunc_r <= funcReq;
            doneFunc_r   <= 4'h0;
            state_r      <= flyMode ? ST_FLYING : ST_SEARCH; // [R1]
          end
        end
        ST_SEARCH:
        begin
          // mode change or dropped command cancels the search
          if (!activate || flyMode || parked_r)
          begin
            activeFunc_r <= 4'h0;
            state_r      <= ST_IDLE;
          end
          else if (|(activeFunc_r & camHere))
          begin
            doneFunc_r   <= activeFunc_r & camHere; // [R11]
            activeFunc_r <= 4'h0;
            state_r      <= ST_IDLE;
          end
        end
        ST_FLYING:
        begin
          if (!activate || !flyMode || parked_r)
          begin
            activeFunc_r <= 4'h0;
            state_r      <= ST_IDLE;
          end
          else
          begin
            // each edge completes on its own; others stay armed
            doneFunc_r   <= doneFunc_r | (activeFunc_r & edgeNow); // [R11]
            activeFunc_r <= activeFunc_r & ~edgeNow; // [R10]
            if ((activeFunc_r & ~edgeNow) == 4'h0)
              state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r      <= ST_IDLE;
          activeFunc_r <= 4'h0;
        end
      endcase
    end
  end

  // activate is taken on its step; idle level of the bit is zero
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      actPrev_r <= 1'b0;
    end
    else
    begin
      actPrev_r <= activate; // [R4]
    end
  end

  // acknowledge edge detector; idle level of the bit is zero
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ackPrev_r <= 1'b0;
    end
    else
    begin
      ackPrev_r <= ackBit; // [R8]
    end
  end

  // next values of the acknowledge counter and fault flag
  always @*
  begin
    ackCount_nxt = ackCount_r;
    fault_nxt    = fault_r;
    if (ackRise)
    begin
      ackCount_nxt = `ERC_ACK_CYCLES; // [R13]
    end
    else if (ackCount_r != 4'h0)
    begin
      ackCount_nxt = ackCount_r - 4'h1;
    end
    // a new fault wins over an acknowledge ending in the same cycle
    if (encoderFaultIn)
    begin
      fault_nxt = 1'b1; // [R16]
    end
    else if (ackCount_r == 4'h1)
    begin
      fault_nxt = 1'b0; // [R8]
    end
  end

  // acknowledge counter and fault flag
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ackCount_r <= 4'h0;
      fault_r    <= 1'b0;
    end
    else
    begin
      ackCount_r <= ackCount_nxt;
      fault_r    <= fault_nxt;
    end
  end

  // parking and cyclic transfer; cyclic transfer stops while parked
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      parked_r   <= 1'b0;
      cyclicOn_r <= 1'b0;
    end
    else
    begin
      parked_r   <= encoderControlWord[`ERC_CW_PARK]; // [R7]
      cyclicOn_r <= encoderControlWord[`ERC_CW_CYCLIC] & ~parked_r; // [R6]
    end
  end

  // position sample, frozen while parked so the last value stays readable
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      position_r <= 32'h00000000; // [R17]
    end
    else if (!parked_r)
    begin
      position_r <= encoderPosition;
    end
  end

  // status word, every bit from a flop
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      encoderStatusWord <= `ERC_WORD_RESET;
    end
    else
    begin
      encoderStatusWord[3:0]   <= activeFunc_r; // [R9] [R10]
      encoderStatusWord[7:4]   <= doneFunc_r; // [R11]
      encoderStatusWord[`ERC_SW_CAM1]    <= camSync1b_r; // [R12]
      encoderStatusWord[`ERC_SW_CAM2]    <= camSync2b_r; // [R12]
      encoderStatusWord[10]    <= 1'b0; // [R19]
      encoderStatusWord[`ERC_SW_ACKBUSY] <= (ackCount_r != 4'h0) | ackRise; // [R13]
      encoderStatusWord[12]    <= 1'b0; // [R19]
      encoderStatusWord[`ERC_SW_CYCLIC]  <= cyclicOn_r & ~unsupported; // [R14]
      encoderStatusWord[`ERC_SW_PARKED]  <= parked_r; // [R15]
      encoderStatusWord[`ERC_SW_FAULT]   <= fault_r; // [R16]
    end
  end

  // fault code only while the fault flag stands; zero otherwise
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      faultCodeParameter <= 32'h00000000;
    end
    else if (fault_r)
    begin
      faultCodeParameter <= encoderFaultCode; // [R16]
    end
    else
    begin
      faultCodeParameter <= 32'h00000000;
    end
  end

  // secondary word: error codes win over values; holds last word when nothing asked
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      secondaryPosition <= 32'h00000000; // [R17]
    end
    else if (unsupported)
    begin
      secondaryPosition <= `ERC_ERR_UNSUPPORTED; // [R18]
    end
    else if (readReq && funcReq == 4'h0)
    begin
      secondaryPosition <= `ERC_ERR_READ_CANCEL; // nothing selected to read
    end
    else if (readReq)
    begin
      secondaryPosition <= position_r; // [R5]
    end
    else if (cyclicOn_r)
    begin
      secondaryPosition <= position_r; // [R6] [R14]
    end
  end

endmodule // erc_encoder_referencing_control

// ===== erc_defines.vh
// constants for the encoder referencing control block
`ifndef ERC_DEFINES_VH
`define ERC_DEFINES_VH
`define ERC_CW_FUNC_LO     0
`define ERC_CW_FUNC_HI     3
`define ERC_CW_ACTIVATE    4
`define ERC_CW_READ        5
`define ERC_CW_MODE        7
`define ERC_CW_CYCLIC      13
`define ERC_CW_PARK        14
`define ERC_CW_ACK         15
`define ERC_SW_CAM1        8
`define ERC_SW_CAM2        9
`define ERC_SW_ACKBUSY     11
`define ERC_SW_CYCLIC      13
`define ERC_SW_PARKED      14
`define ERC_SW_FAULT       15
`define ERC_ERR_UNSUPPORTED 32'h00000F01
`define ERC_ERR_PARK_CANCEL 32'h00000003
`define ERC_ERR_READ_CANCEL 32'h00000005
`define ERC_ACK_CYCLES     4'h4
`define ERC_WORD_RESET     16'h0000
`endif

// ===== erc_ref_chk.sv
// assertion checker for the encoder referencing control block
module erc_ref_chk (
  input wire logic        clk_sys,            // system clock
  input wire logic        rst,                // async reset
  input wire logic [15:0] encoderControlWord, // control word
  input wire logic        camLevel1,          // cam 1 pin
  input wire logic        camLevel2,          // cam 2 pin
  input wire logic        encoderFaultIn,     // fault level
  input wire logic [3:0]  funcSupported,      // supported functions
  input wire logic [15:0] encoderStatusWord,  // status word
  input wire logic [31:0] secondaryPosition,  // secondary word
  input wire logic [31:0] faultCodeParameter  // fault code
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [15:0] c = encoderControlWord;
  wire [15:0] s = encoderStatusWord;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // idle, supported, single request: anything else has no fixed answer
  sequence actReq;
    $rose(c[4]) && $onehot(c[3:0]) && (c[3:0] & ~funcSupported) == 4'h0
      && s[3:0] == 4'h0 && !s[14];
  endsequence
  sequence ackRise;
    $rose(c[15]);
  endsequence
  sequence unsupReq;
    c[4] && (c[3:0] & ~funcSupported) != 4'h0;
  endsequence
  chk_act_start: assert property (actReq |-> ##2 s[3:0] == $past(c[3:0], 2))
    else $error("requested function not shown active");
  chk_rsvd_zero: assert property (s[10] == 1'b0 && s[12] == 1'b0)
    else $error("reserved status bit set");
  chk_cam_mirror: assert property (s[9:8] == {$past(camLevel2, 3), $past(camLevel1, 3)})
    else $error("cam level not mirrored");
  chk_ack_start: assert property (ackRise |=> s[11])
    else $error("ack busy did not follow ack edge");
  chk_ack_edge: assert property ($rose(s[11]) |-> $past(c[15]) && !$past(c[15], 2))
    else $error("ack busy without ack edge");
  chk_ack_hold: assert property ($rose(s[11]) |-> s[11] [*5])
    else $error("ack busy too short");
  chk_fault_set: assert property ($rose(encoderFaultIn) |-> ##[1:2] s[15])
    else $error("fault not flagged");
  chk_fault_code: assert property (!s[15] |-> faultCodeParameter == 32'h00000000)
    else $error("fault code without fault");
  chk_unsup_code: assert property (unsupReq [*3] |-> secondaryPosition == 32'h00000F01)
    else $error("unsupported code missing");
  chk_cyclic_flag: assert property (s[13] |-> $past(c[13]) || $past(c[13], 2))
    else $error("cyclic flag without request");
endmodule // erc_ref_chk

bind erc_encoder_referencing_control erc_ref_chk erc_ref_chk_i (
  .clk_sys(clk_sys), .rst(rst), .encoderControlWord(encoderControlWord),
  .camLevel1(camLevel1), .camLevel2(camLevel2), .encoderFaultIn(encoderFaultIn),
  .funcSupported(funcSupported), .encoderStatusWord(encoderStatusWord),
  .secondaryPosition(secondaryPosition), .faultCodeParameter(faultCodeParameter));

// ===== erc_ctrl_model.sv
// controller-side model that launches the encoder control word
module erc_ctrl_model (
  input  wire logic        clk_sys,  // system clock
  input  wire logic        rst,      // async reset
  input  wire logic [15:0] reqWord,  // word asked for by the bench
  output logic      [15:0] ctrlWord  // word sent toward the drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // reserved bits always leave as zero; ack edges come from bench order
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      ctrlWord <= 16'h0000;
    else
      ctrlWord <= reqWord & 16'hE0BF;
endmodule // erc_ctrl_model

// ===== erc_encoder_referencing_control_tb.sv
// self-checking bench for the encoder referencing control block
module erc_encoder_referencing_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst = 1'b1, cam1 = 1'b0, cam2 = 1'b0, faultIn = 1'b0;
  logic [15:0] req = 16'h0000, ctrl, sw;
  logic [31:0] faultCode = 32'h0, pos = 32'h0, secPos, fcp, seed, r;
  logic [3:0]  funcSup = 4'hF;
  int          errorCnt = 0, nTests = 0;
  erc_ctrl_model erc_ctrl_model_i (.clk_sys(clk_sys), .rst(rst), .reqWord(req), .ctrlWord(ctrl));
  erc_encoder_referencing_control erc_encoder_referencing_control_i (
    .clk_sys(clk_sys), .rst(rst), .encoderControlWord(ctrl), .camLevel1(cam1),
    .camLevel2(cam2), .encoderFaultIn(faultIn), .encoderFaultCode(faultCode),
    .encoderPosition(pos), .funcSupported(funcSup), .encoderStatusWord(sw),
    .secondaryPosition(secPos), .faultCodeParameter(fcp));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] oneHot(input int k);
    return 4'h1 << k[1:0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic set(input logic [15:0] w);
    @(posedge clk_sys);
    req <= w;
  endtask
  // outputs are read at the falling edge, clear of the update edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    errorCnt++;
    giveVerdict();
  end
  initial
  begin
    seed = 32'h6FC6A540;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    wt(2);
    chk(32'(sw), 32'h0);
    chk(secPos, 32'h0);
    repeat (4)
    begin
      r = rnd();
      @(posedge clk_sys);
      {cam2, cam1} <= r[1:0];
      wt(5);
      chk(32'(sw[9:8]), 32'(r[1:0]));
    end
    @(posedge clk_sys);
    {cam2, cam1} <= 2'b00;
    set(16'h0011);
    wt(6);
    chk(32'(sw[7:0]), 32'h01);
    @(posedge clk_sys);
    cam1 <= 1'b1;
    wt(9);
    chk(32'(sw[8:0]), 32'h110);
    @(posedge clk_sys);
    cam1 <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      set({8'h00, k[2], 7'h00});
      wt(3);
      set({8'h00, k[2], 3'b001, oneHot(k)});
      wt(6);
      chk(32'(sw[3:0]), 32'(oneHot(k)));
      if (k == 4 || k == 6)
      begin
        @(posedge clk_sys);
        {cam2, cam1} <= (k == 4) ? 2'b01 : 2'b10;
        wt(9);
        chk(32'(sw[7:4]), 32'(oneHot(k)));
        @(posedge clk_sys);
        {cam2, cam1} <= 2'b00;
      end
    end
    set(16'h0011);
    funcSup <= 4'hE;
    wt(6);
    chk(secPos, 32'h00000F01);
    chk(32'(sw[13]), 32'h0);
    set(16'h0000);
    funcSup <= 4'hF;
    wt(3);
    set(16'h0020);
    wt(6);
    chk(secPos, 32'h00000005);
    r = rnd();
    set(16'h2000);
    pos <= r;
    wt(6);
    chk(32'(sw[13]), 32'h1);
    chk(secPos, r);
    set(16'h4000);
    wt(6);
    chk(32'(sw[14]), 32'h1);
    set(16'h4011);
    wt(6);
    chk(32'(sw[3:0]), 32'h0);
    set(16'h0000);
    r = rnd();
    faultIn <= 1'b1;
    faultCode <= r;
    wt(4);
    chk(32'(sw[15]), 32'h1);
    chk(fcp, r);
    set(16'h8000);
    faultIn <= 1'b0;
    wt(4);
    chk(32'(sw[11]), 32'h1);
    wt(10);
    chk(32'(sw[15:11]), 32'h0);
    chk(fcp, 32'h0);
    giveVerdict();
  end
endmodule // erc_encoder_referencing_control_tb
